// ---- src/bmcc_consts.svh ----
`ifndef BMCC_CONSTS_SVH
`define BMCC_CONSTS_SVH

`define BMCC_ADDR_W        8
`define BMCC_DATA_W        8
`define BMCC_ASYNC_CLOCK_CTRL_STATUS_OFS      8'h00
`define BMCC_SLEEP_CONTROL_REGISTER_OFS      8'h01
`define BMCC_ASYNC_CLOCK_CTRL_STATUS_RST      2'h0
`define BMCC_SLEEP_CONTROL_REGISTER_RST      4'h0
`define BMCC_ACS_BIT       0
`define BMCC_XOE_BIT       1
`define BMCC_SE_BIT        0
`define BMCC_SM_LSB        1
`define BMCC_SM_MSB        3
`define BMCC_SM_POFF       3'h4
`define BMCC_SM_LAST       3'h4
`define BMCC_SLOW_RC_KHZ   131
`define BMCC_ULP_RC_KHZ    128
`define BMCC_TWI_MHZ       4
`define BMCC_CPU_MHZ       1
`define BMCC_CK_WAKE       6
`define BMCC_CK_RESET      14
`define BMCC_CK_STALL      4
`define BMCC_CK_POFF_WIN   4
`define BMCC_ULP_SHORT     500
`define BMCC_ULP_LONG      8000
`define BMCC_SUT_NONE      2'h0
`define BMCC_SUT_SHORT     2'h1
`define BMCC_SUT_LONG      2'h2
`define BMCC_CNT_W         13

`endif

// ---- src/bmcc_pkg.sv ----
package bmcc_pkg;

  typedef enum logic [2:0] {
    BMCC_SM_IDLE,
    BMCC_SM_ADCNR,
    BMCC_SM_PDOWN,
    BMCC_SM_PSAVE,
    BMCC_SM_POFF
  } bmcc_sleep_t;

  typedef enum logic [2:0] {
    BMCC_BOOT,
    BMCC_BOOT_RT,
    BMCC_ACTIVE,
    BMCC_SLEEP,
    BMCC_WAKE,
    BMCC_STALL,
    BMCC_OFF
  } bmcc_state_t;

  typedef enum logic [1:0] {
    BMCC_MUX_RUN,
    BMCC_MUX_GAP
  } bmcc_mux_t;

endpackage : bmcc_pkg

// ---- src/bmcc_clk_mux.sv ----
`timescale 1ns/1ps
module bmcc_clk_mux (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic src0,
  input  wire logic src1,
  input  wire logic sel,
  output logic      clk_q
);

  bmcc_pkg::bmcc_mux_t st_q;
  logic                cur_q;
  logic                cur_src;
  logic                new_src;

  assign cur_src = cur_q ? src1 : src0;
  assign new_src = sel ? src1 : src0;

  // Leave the old source only while it is low, join the new one only while
  // it is low, so no runt pulse reaches the counter ADC or wake timer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q  <= bmcc_pkg::BMCC_MUX_RUN;
      cur_q <= 1'b0;
    end else begin
      case (st_q)
        bmcc_pkg::BMCC_MUX_RUN: begin
          if (sel != cur_q && !cur_src) begin
            st_q <= bmcc_pkg::BMCC_MUX_GAP;
          end
        end
        bmcc_pkg::BMCC_MUX_GAP: begin
          if (!new_src) begin
            cur_q <= sel;
            st_q  <= bmcc_pkg::BMCC_MUX_RUN;
          end
        end
        default: st_q <= bmcc_pkg::BMCC_MUX_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= (st_q == bmcc_pkg::BMCC_MUX_RUN) ? cur_src : 1'b0;
    end
  end

endmodule : bmcc_clk_mux

// ---- src/bmcc_top.sv ----
// Behaviour
// - Slow RC supplies a fixed 131 kHz clock, run-time or crystal fallback.
// - Ultra-low-power RC supplies a 128 kHz low-accuracy clock.
// - Fast RC feeds two-wire serial at 4 MHz, everything else at 1 MHz.
// - Wake from power-down or power-save waits 6 CPU clocks first.
// - Reset delay by fuses: 14 clocks, plus 3.9 ms or 62.5 ms.
// - Real-time reset delay counts 500 or 8000 ULP oscillator cycles.
// - Async clock is crystal or slow RC divided by four.
// - Select bit 0: zero picks slow RC, one picks crystal.
// - Crystal enable bit 1 powers the crystal regardless of selection.
// - Writing select one with enable zero clears both bits.
// - Bits 7:2 of clock control read zero; register resets to zero.
// - Oscillator enables follow sleep mode per the gating table.
// - ULP oscillator runs when watchdog or battery protection on outside power-off, and in reset.
// - Sleep only when permit bit set at sleep instruction; five modes.
// - Interrupt wake stalls four clocks beyond start-up, then services it.
// - State kept in all sleeps but power-off; leaving power-off resets.
// - Reset during sleep wakes and starts from the reset vector.
// - Mode codes: 000 idle, 001 noise, 010 down, 011 save, 100 off.
// - Power-off with permit set clears sleep control after 4 cycles.
`timescale 1ns/1ps
`include "bmcc_consts.svh"
module bmcc_top #(
  parameter int unsigned ULP_SHORT_CYCLES = `BMCC_ULP_SHORT,
  parameter int unsigned ULP_LONG_CYCLES  = `BMCC_ULP_LONG
) (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic [`BMCC_ADDR_W-1:0] addr,
  input  wire logic [`BMCC_DATA_W-1:0] wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [`BMCC_DATA_W-1:0] rdata_q,
  input  wire logic                    fast_rc_clk,
  input  wire logic                    slow_rc_clk,
  input  wire logic                    ulp_clk,
  input  wire logic                    xtal_clk,
  input  wire logic [1:0]              startup_delay_fuses,
  input  wire logic                    sleep_instr,
  input  wire logic                    wake_irq,
  input  wire logic                    counter_adc_on,
  input  wire logic                    wake_timer_on,
  input  wire logic                    wdt_on,
  input  wire logic                    batt_prot_on,
  output logic                         twi_clk_q,
  output logic                         io_clk_q,
  output logic                         cpu_clk_q,
  output logic                         async_clk_q,
  output logic                         fast_rc_en_q,
  output logic                         slow_rc_en_q,
  output logic                         ulp_en_q,
  output logic                         xosc_en_q,
  output logic                         cpu_run_q,
  output logic                         reset_vector_q,
  output logic                         irq_service_q,
  output logic                         poweroff_req_q,
  output logic                         retain_q,
  output logic                         sleeping_q
);

  localparam int unsigned SYNC_W = 6;

  logic [SYNC_W-1:0]          s1_q;
  logic [SYNC_W-1:0]          s2_q;
  logic [3:0]                 s3_q;
  logic                       fast_rise;
  logic                       slow_rise;
  logic                       ulp_rise;
  logic [1:0]                 div_q;
  logic [1:0]                 slow_div_q;
  logic                       ck_tick;
  logic [1:0]                 async_clock_ctrl_status_q;
  logic [3:0]                 sleep_control_register_q;
  logic [2:0]                 poff_cnt_q;
  logic                       poff_arm_q;
  logic [1:0]                 fuse_q;
  logic [`BMCC_CNT_W-1:0]     cnt_q;
  bmcc_pkg::bmcc_state_t      st_q;
  bmcc_pkg::bmcc_state_t      st_d;
  bmcc_pkg::bmcc_sleep_t      mode_q;
  logic                       io_run;
  logic                       async_clk;
  logic                       async_clock_ctrl_status_wr;
  logic                       sleep_control_register_wr;
  logic                       poff_expire;
  logic                       go_sleep;
  logic [2:0]                 sm_field;

  function automatic logic mode_valid(input logic [2:0] code);
    mode_valid = (code <= `BMCC_SM_LAST);
  endfunction : mode_valid

  function automatic logic mode_deep(input bmcc_pkg::bmcc_sleep_t m);
    mode_deep = (m == bmcc_pkg::BMCC_SM_PDOWN) || (m == bmcc_pkg::BMCC_SM_PSAVE);
  endfunction : mode_deep

  // Oscillators and fuses arrive from outside this clock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {startup_delay_fuses, xtal_clk, ulp_clk, slow_rc_clk, fast_rc_clk};
      s2_q <= s1_q;
      s3_q <= s2_q[3:0];
    end
  end

  assign fast_rise = s2_q[0] & ~s3_q[0];
  assign slow_rise = s2_q[1] & ~s3_q[1];
  assign ulp_rise  = s2_q[2] & ~s3_q[2];
  assign ck_tick   = fast_rise && (div_q == 2'h3);

  // 4 MHz divided by four gives the 1 MHz module clock
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      div_q <= 2'h0;
    end else if (fast_rise) begin
      div_q <= div_q + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      slow_div_q <= 2'h0;
    end else if (slow_rise) begin
      slow_div_q <= slow_div_q + 2'h1;
    end
  end

  assign io_run = (st_q != bmcc_pkg::BMCC_OFF) &&
                  !(st_q == bmcc_pkg::BMCC_SLEEP && mode_q != bmcc_pkg::BMCC_SM_IDLE);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      twi_clk_q <= 1'b0;
      io_clk_q  <= 1'b0;
      cpu_clk_q <= 1'b0;
    end else begin
      twi_clk_q <= s2_q[0] & fast_rc_en_q;
      io_clk_q  <= div_q[1] & io_run;
      cpu_clk_q <= div_q[1] & (st_q == bmcc_pkg::BMCC_ACTIVE);
    end
  end

  bmcc_clk_mux u_mux (
    .mclk    (mclk),
    .reset_n (reset_n),
    .src0    (slow_div_q[1]),
    .src1    (s2_q[3]),
    .sel     (async_clock_ctrl_status_q[`BMCC_ACS_BIT]),
    .clk_q   (async_clk)
  );

  assign async_clk_q = async_clk;

  assign async_clock_ctrl_status_wr  = wr && (addr == `BMCC_ASYNC_CLOCK_CTRL_STATUS_OFS);
  assign sleep_control_register_wr  = wr && (addr == `BMCC_SLEEP_CONTROL_REGISTER_OFS);
  assign sm_field = sleep_control_register_q[`BMCC_SM_MSB:`BMCC_SM_LSB];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      async_clock_ctrl_status_q <= `BMCC_ASYNC_CLOCK_CTRL_STATUS_RST;
    end else if (async_clock_ctrl_status_wr) begin
      // A disabled crystal must never become the source
      if (wdata[`BMCC_ACS_BIT] && !wdata[`BMCC_XOE_BIT]) begin
        async_clock_ctrl_status_q <= 2'h0;
      end else begin
        async_clock_ctrl_status_q <= wdata[1:0];
      end
    end
  end

  // Power-off arming window; a software write in the expiry cycle wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      poff_arm_q <= 1'b0;
      poff_cnt_q <= 3'h0;
    end else if (sleep_control_register_wr) begin
      poff_arm_q <= wdata[`BMCC_SE_BIT] && (wdata[`BMCC_SM_MSB:`BMCC_SM_LSB] == `BMCC_SM_POFF);
      poff_cnt_q <= 3'h0;
    end else if (poff_expire || go_sleep) begin
      poff_arm_q <= 1'b0;
      poff_cnt_q <= 3'h0;
    end else if (poff_arm_q && ck_tick) begin
      poff_cnt_q <= poff_cnt_q + 3'h1;
    end
  end

  assign poff_expire = poff_arm_q && ck_tick && (poff_cnt_q == 3'(`BMCC_CK_POFF_WIN - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sleep_control_register_q <= `BMCC_SLEEP_CONTROL_REGISTER_RST;
    end else if (sleep_control_register_wr) begin
      sleep_control_register_q <= wdata[3:0];
    end else if (poff_expire) begin
      sleep_control_register_q <= `BMCC_SLEEP_CONTROL_REGISTER_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else if (rd && addr == `BMCC_ASYNC_CLOCK_CTRL_STATUS_OFS) begin
      rdata_q <= {6'h00, async_clock_ctrl_status_q};
    end else if (rd && addr == `BMCC_SLEEP_CONTROL_REGISTER_OFS) begin
      rdata_q <= {4'h0, sleep_control_register_q};
    end else begin
      rdata_q <= '0;
    end
  end

  assign go_sleep = (st_q == bmcc_pkg::BMCC_ACTIVE) && sleep_instr &&
                    sleep_control_register_q[`BMCC_SE_BIT] && mode_valid(sm_field);

  always_comb begin
    st_d = st_q;
    case (st_q)
      bmcc_pkg::BMCC_BOOT: begin
        if (ck_tick && cnt_q == `BMCC_CNT_W'(`BMCC_CK_RESET - 1)) begin
          st_d = (fuse_q == `BMCC_SUT_SHORT || fuse_q == `BMCC_SUT_LONG) ?
                 bmcc_pkg::BMCC_BOOT_RT : bmcc_pkg::BMCC_ACTIVE;
        end
      end
      bmcc_pkg::BMCC_BOOT_RT: begin
        if (ulp_rise && ((fuse_q == `BMCC_SUT_SHORT && cnt_q == `BMCC_CNT_W'(ULP_SHORT_CYCLES - 1)) ||
                         (fuse_q == `BMCC_SUT_LONG && cnt_q == `BMCC_CNT_W'(ULP_LONG_CYCLES - 1)))) begin
          st_d = bmcc_pkg::BMCC_ACTIVE;
        end
      end
      bmcc_pkg::BMCC_ACTIVE: begin
        if (go_sleep) begin
          st_d = (sm_field == `BMCC_SM_POFF) ? bmcc_pkg::BMCC_OFF : bmcc_pkg::BMCC_SLEEP;
        end
      end
      bmcc_pkg::BMCC_SLEEP: begin
        if (wake_irq) begin
          st_d = mode_deep(mode_q) ? bmcc_pkg::BMCC_WAKE : bmcc_pkg::BMCC_STALL;
        end
      end
      bmcc_pkg::BMCC_WAKE: begin
        if (ck_tick && cnt_q == `BMCC_CNT_W'(`BMCC_CK_WAKE - 1)) begin
          st_d = bmcc_pkg::BMCC_STALL;
        end
      end
      bmcc_pkg::BMCC_STALL: begin
        if (ck_tick && cnt_q == `BMCC_CNT_W'(`BMCC_CK_STALL - 1)) begin
          st_d = bmcc_pkg::BMCC_ACTIVE;
        end
      end
      bmcc_pkg::BMCC_OFF: begin
        // Any wake from power-off restarts as a full reset
        if (wake_irq) begin
          st_d = bmcc_pkg::BMCC_BOOT;
        end
      end
      default: st_d = bmcc_pkg::BMCC_BOOT;
    endcase
  end

  // Reset during sleep lands here too, so execution restarts at the vector
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_q <= bmcc_pkg::BMCC_BOOT;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (st_d != st_q) begin
      cnt_q <= '0;
    end else if ((st_q == bmcc_pkg::BMCC_BOOT_RT) ? ulp_rise : ck_tick) begin
      cnt_q <= cnt_q + `BMCC_CNT_W'(1);
    end
  end

  // Fuses sampled while booting, after the reset release
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fuse_q <= `BMCC_SUT_NONE;
    end else if (st_q == bmcc_pkg::BMCC_BOOT && cnt_q == '0) begin
      fuse_q <= s2_q[5:4];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_q <= bmcc_pkg::BMCC_SM_IDLE;
    end else if (go_sleep) begin
      mode_q <= bmcc_pkg::bmcc_sleep_t'(sm_field);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cpu_run_q      <= 1'b0;
      reset_vector_q <= 1'b0;
      irq_service_q  <= 1'b0;
      poweroff_req_q <= 1'b0;
      retain_q       <= 1'b1;
      sleeping_q     <= 1'b0;
    end else begin
      cpu_run_q      <= (st_d == bmcc_pkg::BMCC_ACTIVE);
      reset_vector_q <= (st_q == bmcc_pkg::BMCC_BOOT || st_q == bmcc_pkg::BMCC_BOOT_RT) &&
                        (st_d == bmcc_pkg::BMCC_ACTIVE);
      irq_service_q  <= (st_q == bmcc_pkg::BMCC_STALL) && (st_d == bmcc_pkg::BMCC_ACTIVE);
      poweroff_req_q <= (st_d == bmcc_pkg::BMCC_OFF);
      retain_q       <= (st_d != bmcc_pkg::BMCC_OFF);
      sleeping_q     <= (st_d == bmcc_pkg::BMCC_SLEEP) || (st_d == bmcc_pkg::BMCC_OFF);
    end
  end

  // Crystal stabilisation is left to software timing via the wake timer
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fast_rc_en_q <= 1'b1;
      slow_rc_en_q <= 1'b1;
      ulp_en_q     <= 1'b1;
      xosc_en_q    <= 1'b0;
    end else begin
      case (st_d)
        bmcc_pkg::BMCC_OFF: begin
          fast_rc_en_q <= 1'b0;
          slow_rc_en_q <= 1'b0;
          ulp_en_q     <= 1'b0;
          xosc_en_q    <= 1'b0;
        end
        bmcc_pkg::BMCC_SLEEP: begin
          fast_rc_en_q <= !mode_deep(go_sleep ? bmcc_pkg::bmcc_sleep_t'(sm_field) : mode_q);
          ulp_en_q     <= wdt_on | batt_prot_on;
          if ((go_sleep ? bmcc_pkg::bmcc_sleep_t'(sm_field) : mode_q) == bmcc_pkg::BMCC_SM_PDOWN) begin
            slow_rc_en_q <= 1'b0;
            xosc_en_q    <= 1'b0;
          end else begin
            slow_rc_en_q <= async_clock_ctrl_status_q[`BMCC_ACS_BIT] & (counter_adc_on | wake_timer_on);
            xosc_en_q    <= async_clock_ctrl_status_q[`BMCC_XOE_BIT];
          end
        end
        bmcc_pkg::BMCC_BOOT, bmcc_pkg::BMCC_BOOT_RT: begin
          fast_rc_en_q <= 1'b1;
          slow_rc_en_q <= 1'b1;
          ulp_en_q     <= 1'b1;
          xosc_en_q    <= async_clock_ctrl_status_q[`BMCC_XOE_BIT];
        end
        default: begin
          fast_rc_en_q <= 1'b1;
          slow_rc_en_q <= 1'b1;
          ulp_en_q     <= wdt_on | batt_prot_on;
          xosc_en_q    <= async_clock_ctrl_status_q[`BMCC_XOE_BIT];
        end
      endcase
    end
  end

endmodule : bmcc_top

// ---- tb/bmcc_monitor.sv ----
`timescale 1ns/1ps
module bmcc_monitor (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata_q,
  input wire logic       sleep_instr,
  input wire logic       wake_irq,
  input wire logic       wdt_on,
  input wire logic       batt_prot_on,
  input wire logic       cpu_clk_q,
  input wire logic       slow_rc_en_q,
  input wire logic       ulp_en_q,
  input wire logic       xosc_en_q,
  input wire logic       cpu_run_q,
  input wire logic       irq_service_q,
  input wire logic       poweroff_req_q,
  input wire logic       retain_q,
  input wire logic       sleeping_q
);
  localparam int WAKE_MIN = 700;
  localparam int WAKE_MAX = 3500;
  logic [11:0] wake_cnt_q;

  default clocking mon_cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Stall is 700 cycles or more, too long for a repetition
  always_ff @(posedge mclk) begin
    if (!reset_n || irq_service_q) begin
      wake_cnt_q <= 12'h000;
    end else if (wake_cnt_q != 12'h000 || (wake_irq && sleeping_q && !poweroff_req_q)) begin
      wake_cnt_q <= wake_cnt_q + 12'h001;
    end
  end

  sequence s_reg_read;
    rd;
  endsequence
  sequence s_async_clock_ctrl_status_read;
    rd && addr == 8'h00;
  endsequence

  chk_rdata_idle: assert property (!rd |=> rdata_q == 8'h00) else $error("read data not zero");
  chk_upper_zero: assert property (s_reg_read |=> rdata_q[7:4] == 4'h0) else $error("upper bits set");
  chk_async_clock_ctrl_status_bits: assert property (s_async_clock_ctrl_status_read |=> rdata_q[7:2] == 6'h00) else $error("async_clock_ctrl_status high bits set");
  chk_sel_xoe: assert property (s_async_clock_ctrl_status_read |=> !(rdata_q[0] && !rdata_q[1])) else $error("select without xoe");
  chk_sleep_entry: assert property ($rose(sleeping_q) |-> $past(sleep_instr) && !cpu_run_q)
    else $error("sleep without instruction");
  chk_off_gates: assert property (poweroff_req_q && $past(poweroff_req_q) |-> !xosc_en_q && !slow_rc_en_q && !retain_q)
    else $error("oscillator on in power off");
  chk_active_slow: assert property (cpu_run_q && $past(cpu_run_q) |-> slow_rc_en_q) else $error("slow rc off");
  chk_ulp_follow: assert property ((wdt_on || batt_prot_on) && !poweroff_req_q |=> ulp_en_q || poweroff_req_q)
    else $error("ulp off while needed");
  chk_cpu_gated: assert property (!cpu_run_q && !$past(cpu_run_q) |-> !cpu_clk_q) else $error("cpu clock runs");
  chk_wake_stall: assert property ($rose(irq_service_q) |-> wake_cnt_q >= WAKE_MIN && wake_cnt_q <= WAKE_MAX)
    else $error("wake stall length wrong");
endmodule : bmcc_monitor

bind bmcc_top bmcc_monitor u_monitor (.*);

// ---- tb/bmcc_osc_model.sv ----
`timescale 1ns/1ps
module bmcc_osc_model (
  input  wire logic fast_rc_en_q,
  input  wire logic slow_rc_en_q,
  input  wire logic ulp_en_q,
  input  wire logic xosc_en_q,
  output logic      fast_rc_clk,
  output logic      slow_rc_clk,
  output logic      ulp_clk,
  output logic      xtal_clk
);
  // Disabled source sits low, so no stray edge reaches the syncs
  initial begin
    {fast_rc_clk, slow_rc_clk, ulp_clk, xtal_clk} = 4'h0;
  end
  always #125 fast_rc_clk = fast_rc_en_q && !fast_rc_clk;
  always #3816.794 slow_rc_clk = slow_rc_en_q && !slow_rc_clk;
  always #3906.25 ulp_clk = ulp_en_q && !ulp_clk;
  always #15258.789 xtal_clk = xosc_en_q && !xtal_clk;
endmodule : bmcc_osc_model

// ---- tb/tb_clock_source_and_sleep_control.sv ----
`timescale 1ns/1ps
module tb_clock_source_and_sleep_control;
  localparam int TICK = 250;
  localparam int ULP = 1953;
  logic       mclk = 1'b0;
  logic       reset_n, wr, rd, sleep_instr, wake_irq, rd_d = 1'b0;
  logic [7:0] addr, wdata, rdata_q, v;
  logic [1:0] startup_delay_fuses;
  logic       counter_adc_on, wake_timer_on, wdt_on, batt_prot_on;
  logic       fast_rc_clk, slow_rc_clk, ulp_clk, xtal_clk, twi_clk_q, io_clk_q, cpu_clk_q, async_clk_q;
  logic       fast_rc_en_q, slow_rc_en_q, ulp_en_q, xosc_en_q, cpu_run_q, reset_vector_q;
  logic       irq_service_q, poweroff_req_q, retain_q, sleeping_q, pt, pi;
  logic [7:0] exp_q[$];
  logic [7:0] modes[6] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h0B, 8'h00};
  int         miscompares = 0, checks_done = 0, seed, n, tw, io;

  bmcc_top #(.ULP_SHORT_CYCLES(10), .ULP_LONG_CYCLES(20)) dut (.*);
  bmcc_osc_model osc (.*);

  always #2 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic in_range(input string what, input int seen, lo, hi);
    check(what, 32'(seen >= lo && seen <= hi), 32'h1);
  endtask : in_range

  task automatic wr_reg(input logic [7:0] a, d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask : rd_reg

  task automatic go_sleep();
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : go_sleep

  // Returns just after the edge that shows the pulse
  task automatic wait_pulse(input bit svc, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while ((svc ? irq_service_q : reset_vector_q) !== 1'b1 && cnt < 40000);
  endtask : wait_pulse

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk) rd_d <= rd;
  always @(negedge mclk) begin
    if (rd_d && exp_q.size() > 0) check("read data", 32'(rdata_q), 32'(exp_q.pop_front()));
  end

  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    seed = 99653;
    {reset_n, wr, rd, sleep_instr, wake_irq, wdt_on, wake_timer_on} = 7'h00;
    {addr, wdata, startup_delay_fuses} = 18'h00000;
    {counter_adc_on, batt_prot_on} = 2'h3;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    wait_pulse(1'b0, n);
    in_range("boot delay", n, 13 * TICK, 15 * TICK + 200);
    @(posedge mclk);
    rd_reg(8'h00, 8'h00);
    wr_reg(8'h00, 8'hFD);
    rd_reg(8'h00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr_reg(8'h00, v);
      rd_reg(8'h00, (v[0] && !v[1]) ? 8'h00 : {6'h00, v[1:0]});
      wr_reg(v | 8'h02, v);
      rd_reg(v | 8'h02, 8'h00);
      v = v & 8'hFE;
      wr_reg(8'h01, v);
      rd_reg(8'h01, {4'h0, v[3:0]});
    end
    done("registers");
    {tw, io, pt, pi} = 66'h0;
    repeat (2000) begin
      @(posedge mclk);
      #1;
      tw += int'(twi_clk_q && !pt);
      io += int'(io_clk_q && !pi);
      {pt, pi} = {twi_clk_q, io_clk_q};
    end
    in_range("fast clock edges", tw, 31, 33);
    in_range("divided clock edges", io, 7, 9);
    wr_reg(8'h00, 8'h00);
    {tw, pt} = 33'h0;
    repeat (16000) begin
      @(posedge mclk);
      #1;
      tw += int'(async_clk_q && !pt);
      pt = async_clk_q;
    end
    in_range("async clock edges", tw, 1, 3);
    @(posedge mclk);
    done("clock ratio");
    wr_reg(8'h00, 8'h02);
    wr_reg(8'h00, 8'h03);
    rd_reg(8'h00, 8'h03);
    foreach (modes[i]) begin
      batt_prot_on <= 1'($random(seed));
      wr_reg(8'h01, modes[i]);
      go_sleep();
      check("sleeping", 32'(sleeping_q), 32'(modes[i][0] && modes[i][3:1] < 3'h4));
      if (modes[i][0] && modes[i][3:1] < 3'h4) begin
        check("crystal in sleep", 32'(xosc_en_q), 32'(modes[i][3:1] != 3'h2));
        check("slow rc in sleep", 32'(slow_rc_en_q), 32'(modes[i][3:1] != 3'h2));
        @(posedge mclk);
        wake_irq <= 1'b1;
        wait_pulse(1'b1, n);
        if (modes[i][2]) in_range("deep wake", n, 9 * TICK, 11 * TICK + 200);
        else in_range("light wake", n, 3 * TICK, 5 * TICK + 200);
        check("running after wake", 32'(cpu_run_q), 32'h1);
        @(posedge mclk);
        wake_irq <= 1'b0;
      end
      @(posedge mclk);
    end
    done("sleep modes");
    wr_reg(8'h01, 8'h09);
    repeat (6 * TICK) @(posedge mclk);
    rd_reg(8'h01, 8'h00);
    wr_reg(8'h01, 8'h09);
    go_sleep();
    check("power off", 32'(poweroff_req_q), 32'h1);
    check("retention", 32'(retain_q), 32'h0);
    @(posedge mclk);
    wake_irq <= 1'b1;
    wait_pulse(1'b0, n);
    in_range("boot after off", n, 13 * TICK, 15 * TICK + 200);
    @(posedge mclk);
    wake_irq <= 1'b0;
    done("power off");
    wr_reg(8'h00, 8'h02);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h00, 8'h00);
    startup_delay_fuses <= 2'h1;
    wr_reg(8'h01, 8'h01);
    go_sleep();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    wait_pulse(1'b0, n);
    in_range("boot with fuse", n, 13 * TICK + 9 * ULP, 15 * TICK + 11 * ULP);
    check("running after reset", 32'(cpu_run_q), 32'h1);
    @(posedge mclk);
    rd_reg(8'h01, 8'h00);
    done("reset in sleep");
    report_and_stop();
  end
endmodule : tb_clock_source_and_sleep_control
